// ---- hw/fault_status_pkg.sv ----
// Overview of operation
// - Load-current, input and thermal bytes answer at codes 7Bh, 7Ch, 7Dh.
// - Communication, logic and memory byte answers at code 7Eh, read and write.
// - Latched flags clear on the global clear command or a written one.
// - Load overcurrent fault latches bit 7 of the load-current byte.
// - Load overcurrent warning latches bit 5 of the load-current byte.
// - Load undercurrent fault latches bit 4 until cleared.
// - Unsupported bit positions always read as zero.
// - Input overvoltage fault latches bit 7 of the input byte.
// - Input undervoltage warning latches bit 5 and may raise the alert.
// - Undervoltage warning stays masked until input first passes turn-on threshold.
// - Input byte bit 3 is live: one while input or bias is too low.
// - Input-off live bit is set out of reset and never raises the alert.
// - Thermal byte bit 7 latches overtemperature fault, bit 6 the warning.
// - Link_error_flag byte bit 7 latches bad command, bit 6 bad payload.
// - Link_error_flag byte bit 5 latches a packet error check failure.
// - Link_error_flag byte bit 4 latches memory error, bit 3 logic core error.
// - Link_error_flag byte bit 1 latches link errors; bits 2 and 0 read zero.
// - A loop follower reports back-channel trouble as its own link error.
// - Summary link_error_flag bit is the OR of the supported link_error_flag flags.
// - Clearing link_error_flag flags by ones also clears the summary bit.
// - Every alert-capable flag has its own mask bit blocking the alert.
// - Summary bits mirror the latched flags of each status byte; the input-off live bit is left out.
package fault_status_pkg;
   localparam logic [7:0] CODE_CLEAR = 8'h03;
   localparam logic [7:0] CODE_LOAD_CURRENT = 8'h7B;
   localparam logic [7:0] CODE_INPUT_SUPPLY = 8'h7C;
   localparam logic [7:0] CODE_THERMAL = 8'h7D;
   localparam logic [7:0] CODE_LINK_ERROR_FLAG = 8'h7E;

   localparam int BIT_LOAD_OC_FAULT = 7;
   localparam int BIT_LOAD_OC_WARN = 5;
   localparam int BIT_LOAD_UC_FAULT = 4;
   localparam int BIT_INPUT_OV_FAULT = 7;
   localparam int BIT_INPUT_UV_WARN = 5;
   localparam int BIT_INPUT_OFF_LIVE = 3;
   localparam int BIT_TEMP_FAULT = 7;
   localparam int BIT_TEMP_WARN = 6;
   localparam int BIT_BAD_COMMAND = 7;
   localparam int BIT_BAD_PAYLOAD = 6;
   localparam int BIT_PEC_FAIL = 5;
   localparam int BIT_MEMORY_ERR = 4;
   localparam int BIT_LOGIC_CORE_ERR = 3;
   localparam int BIT_LINK_ERR = 1;

   localparam logic [7:0] SUPPORTED_LOAD = 8'hB0;
   localparam logic [7:0] SUPPORTED_INPUT = 8'hA0;
   localparam logic [7:0] SUPPORTED_THERMAL = 8'hC0;
   localparam logic [7:0] SUPPORTED_LINK_ERROR_FLAG = 8'hFA;

   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic INPUT_OFF_RESET = 1'b1;
   localparam int SYNC_LEVELS = 3;
endpackage

// ---- hw/status_byte_if.sv ----
`timescale 1ns/1ns
interface status_byte_if;
   logic [7:0] set_evt;
   logic [7:0] one_clear;
   logic clear_all;
   logic [7:0] flags;
   modport owner (input set_evt, input one_clear, input clear_all,
                  output flags);
   modport user (output set_evt, output one_clear, output clear_all,
                 input flags);
endinterface

// ---- hw/latched_status_byte.sv ----
`timescale 1ns/1ns
module latched_status_byte #(
   parameter logic [7:0] SUPPORTED = 8'hFF
) (
   input wire logic clk,
   input wire logic rst_n,
   status_byte_if.owner sb
);
   import fault_status_pkg::*;

   logic [7:0] flags;
   logic [7:0] next_flags;

   // New events beat a clear in the same cycle so none is lost
   always_comb begin
      if (sb.clear_all) begin
         next_flags = sb.set_evt & SUPPORTED;
      end else begin
         next_flags = ((flags & ~sb.one_clear) | sb.set_evt)
                      & SUPPORTED;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= STATUS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   assign sb.flags = flags;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_set_latches: assert property (
      (sb.set_evt & SUPPORTED) != 8'h00
      |=> (flags & $past(sb.set_evt & SUPPORTED))
          == $past(sb.set_evt & SUPPORTED))
      else $error("Latched flag missed its event");
   a_flag_holds: assert property (
      !sb.clear_all && sb.one_clear == 8'h00
      |=> (flags & $past(flags)) == $past(flags))
      else $error("Flag fell without a clear");
   a_unsupported_zero: assert property (
      (flags & ~SUPPORTED) == 8'h00)
      else $error("Unsupported position reads one");
endmodule

// ---- hw/fault_status_bank.sv ----
`timescale 1ns/1ns
module fault_status_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic mask_valid,
   input wire logic [7:0] mask_code,
   input wire logic [7:0] mask_data,
   input wire logic load_oc_fault,
   input wire logic load_oc_warn,
   input wire logic load_uc_fault,
   input wire logic input_ov_fault,
   input wire logic input_uv_warn,
   input wire logic above_turn_on_raw,
   input wire logic above_turn_off_raw,
   input wire logic bias_ok_raw,
   input wire logic temp_fault,
   input wire logic temp_warn,
   input wire logic bad_command_evt,
   input wire logic bad_payload_evt,
   input wire logic pec_fail_evt,
   input wire logic memory_err_evt,
   input wire logic logic_core_err_evt,
   input wire logic link_err_evt,
   input wire logic loop_follower,
   input wire logic backchannel_err_evt,
   output logic summary_load,
   output logic summary_input,
   output logic summary_thermal,
   output logic summary_link_error_flag,
   output logic alert,
   output logic input_off
);
   import fault_status_pkg::*;

   status_byte_if load_sb ();
   status_byte_if input_sb ();
   status_byte_if thermal_sb ();
   status_byte_if link_error_flag_sb ();

   latched_status_byte #(.SUPPORTED(SUPPORTED_LOAD)) u_load (
      .clk(clk),
      .rst_n(rst_n),
      .sb(load_sb.owner)
   );
   latched_status_byte #(.SUPPORTED(SUPPORTED_INPUT)) u_input (
      .clk(clk),
      .rst_n(rst_n),
      .sb(input_sb.owner)
   );
   latched_status_byte #(.SUPPORTED(SUPPORTED_THERMAL)) u_thermal (
      .clk(clk),
      .rst_n(rst_n),
      .sb(thermal_sb.owner)
   );
   latched_status_byte #(.SUPPORTED(SUPPORTED_LINK_ERROR_FLAG)) u_link_error_flag (
      .clk(clk),
      .rst_n(rst_n),
      .sb(link_error_flag_sb.owner)
   );

   function automatic logic [7:0] bit_at(input int pos, input logic val);
      logic [7:0] b;
      b = 8'h00;
      b[pos] = val;
      return b;
   endfunction

   function automatic logic code_is_ours(input logic [7:0] code);
      return code == CODE_LOAD_CURRENT || code == CODE_INPUT_SUPPLY
         || code == CODE_THERMAL || code == CODE_LINK_ERROR_FLAG;
   endfunction

   // Comparator and bias levels come from the analog side, unclocked
   logic [SYNC_LEVELS-1:0] sync_a;
   logic [SYNC_LEVELS-1:0] sync_b;
   logic above_on;
   logic above_off;
   logic bias_ok;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {above_turn_on_raw, above_turn_off_raw, bias_ok_raw};
         sync_b <= sync_a;
      end
   end
   assign above_on = sync_b[2];
   assign above_off = sync_b[1];
   assign bias_ok = sync_b[0];

   // Conversion state with on/off hysteresis and the warning arm
   logic powered;
   logic next_powered;
   logic uv_armed;
   logic next_uv_armed;
   logic next_input_off;

   always_comb begin
      next_powered = powered ? above_off : above_on;
      next_uv_armed = uv_armed | above_on;
      next_input_off = !(next_powered && bias_ok);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powered <= 1'b0;
         uv_armed <= 1'b0;
         input_off <= INPUT_OFF_RESET;
      end else begin
         powered <= next_powered;
         uv_armed <= next_uv_armed;
         input_off <= next_input_off;
      end
   end

   // Command decode
   logic wr_cmd;
   logic clear_cmd;
   logic unknown_cmd;

   always_comb begin
      wr_cmd = cmd_valid && cmd_write;
      clear_cmd = wr_cmd && cmd_code == CODE_CLEAR;
      unknown_cmd = cmd_valid && !code_is_ours(cmd_code)
                    && cmd_code != CODE_CLEAR;
   end

   // Event routing into the four latched bytes
   always_comb begin
      load_sb.set_evt = bit_at(BIT_LOAD_OC_FAULT, load_oc_fault)
         | bit_at(BIT_LOAD_OC_WARN, load_oc_warn)
         | bit_at(BIT_LOAD_UC_FAULT, load_uc_fault);
      input_sb.set_evt = bit_at(BIT_INPUT_OV_FAULT, input_ov_fault)
         | bit_at(BIT_INPUT_UV_WARN, input_uv_warn && uv_armed);
      thermal_sb.set_evt = bit_at(BIT_TEMP_FAULT, temp_fault)
         | bit_at(BIT_TEMP_WARN, temp_warn);
      link_error_flag_sb.set_evt = bit_at(BIT_BAD_COMMAND,
                               bad_command_evt || unknown_cmd)
         | bit_at(BIT_BAD_PAYLOAD, bad_payload_evt)
         | bit_at(BIT_PEC_FAIL, pec_fail_evt)
         | bit_at(BIT_MEMORY_ERR, memory_err_evt)
         | bit_at(BIT_LOGIC_CORE_ERR, logic_core_err_evt)
         | bit_at(BIT_LINK_ERR, link_err_evt
                  || (loop_follower && backchannel_err_evt));
   end

   // Writing ones clears; zeros and read-only positions are dropped
   always_comb begin
      load_sb.one_clear = (wr_cmd && cmd_code == CODE_LOAD_CURRENT)
                          ? cmd_data : 8'h00;
      input_sb.one_clear = (wr_cmd && cmd_code == CODE_INPUT_SUPPLY)
                           ? cmd_data : 8'h00;
      thermal_sb.one_clear = (wr_cmd && cmd_code == CODE_THERMAL)
                             ? cmd_data : 8'h00;
      link_error_flag_sb.one_clear = (wr_cmd && cmd_code == CODE_LINK_ERROR_FLAG)
                          ? cmd_data : 8'h00;
      load_sb.clear_all = clear_cmd;
      input_sb.clear_all = clear_cmd;
      thermal_sb.clear_all = clear_cmd;
      link_error_flag_sb.clear_all = clear_cmd;
   end

   // Alert masks, one bit per alert-capable flag
   logic [7:0] mask_load;
   logic [7:0] mask_input;
   logic [7:0] mask_thermal;
   logic [7:0] mask_link_error_flag;
   logic [7:0] next_mask_load;
   logic [7:0] next_mask_input;
   logic [7:0] next_mask_thermal;
   logic [7:0] next_mask_link_error_flag;

   always_comb begin
      next_mask_load = mask_load;
      next_mask_input = mask_input;
      next_mask_thermal = mask_thermal;
      next_mask_link_error_flag = mask_link_error_flag;
      if (mask_valid) begin
         unique case (mask_code)
            CODE_LOAD_CURRENT: next_mask_load = mask_data & SUPPORTED_LOAD;
            CODE_INPUT_SUPPLY: next_mask_input = mask_data & SUPPORTED_INPUT;
            CODE_THERMAL: next_mask_thermal = mask_data & SUPPORTED_THERMAL;
            CODE_LINK_ERROR_FLAG: next_mask_link_error_flag = mask_data & SUPPORTED_LINK_ERROR_FLAG;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_load <= MASK_RESET;
         mask_input <= MASK_RESET;
         mask_thermal <= MASK_RESET;
         mask_link_error_flag <= MASK_RESET;
      end else begin
         mask_load <= next_mask_load;
         mask_input <= next_mask_input;
         mask_thermal <= next_mask_thermal;
         mask_link_error_flag <= next_mask_link_error_flag;
      end
   end

   // Read path, summary bits and alert, all registered
   logic [7:0] next_rd_data;
   logic next_rd_valid;
   logic next_alert;
   logic [7:0] input_view;

   always_comb begin
      // Live bit joins only the read view, never the alert term
      input_view = input_sb.flags
                   | bit_at(BIT_INPUT_OFF_LIVE, input_off);
      next_rd_valid = cmd_valid && !cmd_write && code_is_ours(cmd_code);
      next_rd_data = 8'h00;
      if (next_rd_valid) begin
         unique case (cmd_code)
            CODE_LOAD_CURRENT: next_rd_data = load_sb.flags;
            CODE_INPUT_SUPPLY: next_rd_data = input_view;
            CODE_THERMAL: next_rd_data = thermal_sb.flags;
            CODE_LINK_ERROR_FLAG: next_rd_data = link_error_flag_sb.flags;
            default: ;
         endcase
      end
      next_alert = |(load_sb.flags & ~mask_load)
         | |(input_sb.flags & ~mask_input)
         | |(thermal_sb.flags & ~mask_thermal)
         | |(link_error_flag_sb.flags & ~mask_link_error_flag);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         alert <= 1'b0;
         summary_load <= 1'b0;
         summary_input <= 1'b0;
         summary_thermal <= 1'b0;
         summary_link_error_flag <= 1'b0;
      end else begin
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         alert <= next_alert;
         summary_load <= |load_sb.flags;
         summary_input <= |input_sb.flags;
         summary_thermal <= |thermal_sb.flags;
         summary_link_error_flag <= |link_error_flag_sb.flags;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_read_answer: assert property (
      cmd_valid && !cmd_write && cmd_code == CODE_LOAD_CURRENT
      |=> rd_valid && rd_data == $past(load_sb.flags))
      else $error("Load-current read answered wrong");
   a_link_error_flag_read: assert property (
      cmd_valid && !cmd_write && cmd_code == CODE_LINK_ERROR_FLAG
      |=> rd_valid && rd_data[2] == 1'b0 && rd_data[0] == 1'b0)
      else $error("Link_error_flag read wrong");
   a_clear_global: assert property (
      clear_cmd && load_oc_fault == 1'b0
      |=> load_sb.flags[BIT_LOAD_OC_FAULT] == 1'b0)
      else $error("Global clear left a flag");
   a_uv_gated: assert property (
      !uv_armed && !input_sb.flags[BIT_INPUT_UV_WARN] && !clear_cmd
      |=> !input_sb.flags[BIT_INPUT_UV_WARN])
      else $error("Undervoltage warning before turn-on");
   a_live_bit: assert property (
      !bias_ok |=> input_off)
      else $error("Input-off bit low without bias");
   a_follower_link: assert property (
      loop_follower && backchannel_err_evt
      |=> link_error_flag_sb.flags[BIT_LINK_ERR])
      else $error("Back-channel error not reported");
   a_link_error_flag_summary: assert property (
      ##1 summary_link_error_flag == |$past(link_error_flag_sb.flags))
      else $error("Summary link_error_flag bit mismatch");
   a_mask_blocks: assert property (
      ((load_sb.flags & ~mask_load) | (input_sb.flags & ~mask_input)
       | (thermal_sb.flags & ~mask_thermal)
       | (link_error_flag_sb.flags & ~mask_link_error_flag)) == 8'h00 |=> !alert)
      else $error("Alert with all flags masked");
   a_alert_raise: assert property (
      $rose(link_error_flag_sb.flags[BIT_PEC_FAIL]) && !mask_link_error_flag[BIT_PEC_FAIL]
      |=> alert)
      else $error("Alert missed an unmasked flag");

   c_alert_seen: cover property ($rose(alert));
   c_w1c_link_error_flag: cover property (
      summary_link_error_flag ##1 wr_cmd && cmd_code == CODE_LINK_ERROR_FLAG ##2 !summary_link_error_flag);
   c_power_up: cover property ($fell(input_off));
   c_clear_all: cover property (clear_cmd && alert);
endmodule

// ---- verification/pmbus_host_model.sv ----
`timescale 1ns/1ns
module pmbus_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   output logic mask_valid,
   output logic [7:0] mask_code,
   output logic [7:0] mask_data
);
   import fault_status_pkg::*;
   initial begin
      {cmd_valid, cmd_write, mask_valid} = 3'b000;
      {cmd_code, cmd_data} = 16'h0000;
      {mask_code, mask_data} = 16'h0000;
   end
   // Idle lines show the inverse so stale bytes never look valid
   task automatic xfer(input logic w, input logic [7:0] code,
         input logic [7:0] data, output logic [7:0] got,
         output logic got_v);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code = code;
      cmd_data = data;
      @(negedge clk);
      got = rd_data;
      got_v = rd_valid;
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_data = ~data;
   endtask
   task automatic clear_all();
      logic [7:0] got;
      logic v;
      xfer(1'b1, CODE_CLEAR, 8'h00, got, v);
   endtask
   task automatic set_mask(input logic [7:0] code, input logic [7:0] d);
      @(negedge clk);
      mask_valid = 1'b1;
      mask_code = code;
      mask_data = d;
      @(negedge clk);
      mask_valid = 1'b0;
      mask_code = ~code;
      mask_data = ~d;
   endtask
endmodule

// ---- verification/pmbus_fault_status_bytes_tb.sv ----
`timescale 1ns/1ns
module pmbus_fault_status_bytes_tb;
   import fault_status_pkg::*;
   localparam logic [7:0] EV_CODE [14] = '{8'h7B, 8'h7B, 8'h7B, 8'h7C,
      8'h7C, 8'h7D, 8'h7D, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E};
   localparam int EV_BIT [14] = '{7, 5, 4, 7, 5, 7, 6, 7, 6, 5, 4, 3, 1, 1};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid, cmd_write, mask_valid, rd_valid;
   logic [7:0] cmd_code, cmd_data, mask_code, mask_data, rd_data;
   logic [13:0] ev = 14'h0000;
   logic raw_on = 1'b0;
   logic raw_off = 1'b0;
   logic bias_ok = 1'b0;
   logic follower = 1'b1;
   logic summary_load, summary_input, summary_thermal, summary_link_error_flag;
   logic alert, input_off;
   int failures = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h0000_574a;
   logic [13:0] acc;
   logic [7:0] got, b, c;
   logic v;

   always #25 clk = ~clk;

   pmbus_host_model host_u (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .rd_data(rd_data), .rd_valid(rd_valid), .mask_valid(mask_valid),
      .mask_code(mask_code), .mask_data(mask_data));

   fault_status_bank dut_u (.clk(clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .rd_data(rd_data), .rd_valid(rd_valid),
      .mask_valid(mask_valid), .mask_code(mask_code),
      .mask_data(mask_data), .load_oc_fault(ev[0]),
      .load_oc_warn(ev[1]), .load_uc_fault(ev[2]),
      .input_ov_fault(ev[3]), .input_uv_warn(ev[4]),
      .above_turn_on_raw(raw_on), .above_turn_off_raw(raw_off),
      .bias_ok_raw(bias_ok), .temp_fault(ev[5]), .temp_warn(ev[6]),
      .bad_command_evt(ev[7]), .bad_payload_evt(ev[8]),
      .pec_fail_evt(ev[9]), .memory_err_evt(ev[10]),
      .logic_core_err_evt(ev[11]), .link_err_evt(ev[12]),
      .loop_follower(follower), .backchannel_err_evt(ev[13]),
      .summary_load(summary_load), .summary_input(summary_input),
      .summary_thermal(summary_thermal), .summary_link_error_flag(summary_link_error_flag),
      .alert(alert), .input_off(input_off));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction

   function automatic logic [7:0] exp_byte(input logic [7:0] code,
         input logic [13:0] a, input logic off);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 14; i++)
         if (a[i] && EV_CODE[i] == code) r[EV_BIT[i]] = 1'b1;
      if (code == CODE_INPUT_SUPPLY) r[BIT_INPUT_OFF_LIVE] = off;
      return r;
   endfunction

   function automatic logic [13:0] w1c(input logic [13:0] a,
         input logic [7:0] code, input logic [7:0] d);
      logic [13:0] r;
      r = a;
      for (int i = 0; i < 14; i++)
         if (EV_CODE[i] == code && d[EV_BIT[i]]) r[i] = 1'b0;
      return r;
   endfunction

   function automatic logic sum_of(input logic [7:0] code);
      case (code)
         8'h7B: return summary_load;
         8'h7C: return summary_input;
         8'h7D: return summary_thermal;
         default: return summary_link_error_flag;
      endcase
   endfunction

   task automatic check(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic pulse(input logic [13:0] p);
      @(negedge clk);
      ev = p;
      @(negedge clk);
      ev = 14'h0000;
   endtask

   // Waits out the two-cycle lag of summaries and alert first
   task automatic check_all(input logic [13:0] a, input logic off);
      logic [7:0] cc, g;
      logic gv;
      repeat (2) @(negedge clk);
      check("alert", {7'h00, alert}, {7'h00, |a});
      for (int k = 0; k < 4; k++) begin
         cc = 8'h7B + 8'(k);
         check("summary", {7'h00, sum_of(cc)},
            {7'h00, |exp_byte(cc, a, 1'b0)});
         host_u.xfer(1'b0, cc, 8'h00, g, gv);
         check("rd_valid", {7'h00, gv}, 8'h01);
         check("status byte", g, exp_byte(cc, a, off));
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(10000 * 50);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      check("input_off", {7'h00, input_off}, 8'h01);
      pulse(14'h0010);
      check_all(14'h0000, 1'b1);
      host_u.xfer(1'b0, 8'h55, 8'h00, got, v);
      check("refused", {7'h00, v}, 8'h00);
      check_all(14'h0080, 1'b1);
      host_u.clear_all();
      {raw_on, raw_off, bias_ok} = 3'b111;
      repeat (6) @(negedge clk);
      check("input_off", {7'h00, input_off}, 8'h00);
      check_all(14'h0000, 1'b0);
      $display("test reset_and_arm done");
      fork // Set wins over a clear in the same cycle
         pulse(14'h0001);
         host_u.clear_all();
      join
      check_all(14'h0001, 1'b0);
      fork
         pulse(14'h0001);
         host_u.xfer(1'b1, 8'h7B, 8'h80, got, v);
      join
      check_all(14'h0001, 1'b0);
      host_u.clear_all();
      check_all(14'h0000, 1'b0);
      $display("test set_beats_clear done");
      for (int i = 0; i < 14; i++) begin
         acc = 14'h0001 << i;
         pulse(acc);
         check_all(acc, 1'b0);
         b = 8'h01 << EV_BIT[i];
         host_u.xfer(1'b1, EV_CODE[i], ~b, got, v);
         check_all(acc, 1'b0);
         host_u.xfer(1'b1, EV_CODE[i], b, got, v);
         check_all(14'h0000, 1'b0);
      end
      $display("test each_flag done");
      follower = 1'b0;
      pulse(14'h2000);
      check_all(14'h0000, 1'b0);
      follower = 1'b1;
      bias_ok = 1'b0;
      repeat (4) @(negedge clk);
      check("input_off", {7'h00, input_off}, 8'h01);
      check_all(14'h0000, 1'b1);
      {raw_on, bias_ok} = 2'b01;
      repeat (4) @(negedge clk);
      check("hysteresis", {7'h00, input_off}, 8'h00);
      raw_off = 1'b0;
      repeat (4) @(negedge clk);
      check("input_off", {7'h00, input_off}, 8'h01);
      {raw_on, raw_off} = 2'b11;
      repeat (4) @(negedge clk);
      check("input_off", {7'h00, input_off}, 8'h00);
      $display("test power done");
      host_u.set_mask(8'h7D, 8'h80);
      pulse(14'h0020);
      repeat (3) @(negedge clk);
      check("masked", {7'h00, alert}, 8'h00);
      check("thermal", {7'h00, summary_thermal}, 8'h01);
      host_u.set_mask(8'h7D, 8'h00);
      repeat (3) @(negedge clk);
      check("unmasked", {7'h00, alert}, 8'h01);
      for (int k = 0; k < 4; k++) begin
         host_u.set_mask(8'h7B + 8'(k), 8'hFF);
      end
      pulse(14'h3FFF);
      repeat (3) @(negedge clk);
      check("all masked", {7'h00, alert}, 8'h00);
      for (int k = 0; k < 4; k++) begin
         host_u.set_mask(8'h7B + 8'(k), 8'h00);
      end
      repeat (3) @(negedge clk);
      check("all unmasked", {7'h00, alert}, 8'h01);
      host_u.clear_all();
      check_all(14'h0000, 1'b0);
      $display("test mask done");
      for (int k = 0; k < 20; k++) begin
         seed = xs(seed);
         acc = seed[13:0];
         pulse(acc);
         check_all(acc, 1'b0);
         c = 8'h7B + {6'h00, seed[17:16]};
         host_u.xfer(1'b1, c, seed[31:24], got, v);
         check_all(w1c(acc, c, seed[31:24]), 1'b0);
         host_u.clear_all();
         check_all(14'h0000, 1'b0);
      end
      $display("test random done");
      tally_and_finish();
   end
endmodule
